// File: adcrr_top.sv
/*
  Result register block: twelve normal result slots and one priority
  slot, an AHB-Lite slave to read them, and a sticky result-stored
  interrupt with mask. Assumes the converter core gives one-cycle
  done pulses with channel and data, and busy levels for each kind.
*/
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module adcrr_top
  import adcrr_pkg::*;
#(
  parameter int PORT_W = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Converter core
  input wire logic normal_busy,
  input wire logic normal_done,
  input wire logic [adcrr_pkg::CH_W-1:0] normal_ch,
  input wire logic [adcrr_pkg::RES_W-1:0] normal_data,
  input wire logic priority_busy,
  input wire logic priority_done,
  input wire logic [adcrr_pkg::RES_W-1:0] priority_data,
  // Shared port data register bits
  input wire logic [PORT_W-1:0] port_data_register,
  // Interrupt
  output logic irq
);
  import adcrr_pkg::*;

  // ****************************************************************
  // Bus address phase capture
  // ****************************************************************
  logic ph_valid_q;
  logic ph_write_q;
  logic [7:0] ph_addr_q;
  logic take;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase kept for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end else begin
      ph_valid_q <= take;
      ph_write_q <= hwrite;
      ph_addr_q <= haddr;
    end
  end

  // ****************************************************************
  // Read strobes: clear-on-read acts as the read is taken
  // ****************************************************************
  logic [NUM_INT-1:0] rd_pulse;
  logic [NUM_INT-1:0] wr_pulse;
  logic [NUM_INT-1:0] pin_pulse;
  logic [RES_W-1:0] slot_data [NUM_INT];
  logic [RES_W-1:0] slot_res [NUM_INT];
  logic [NUM_INT-1:0] slot_st;
  logic [NUM_INT-1:0] slot_ov;
  logic [NUM_INT-1:0] slot_pc;

  // Port data edge detect; inputs are synchronous so no synchroniser
  logic [PORT_W-1:0] port_prev_q;
  logic port_seen_q;
  logic port_changed;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_prev_q <= '0;
      port_seen_q <= 1'b0;
    end else begin
      port_prev_q <= port_data_register;
      port_seen_q <= 1'b1;
    end
  end

  // The history holds no real pin value on the first edge after reset,
  // so no change is reported there; avoids a false pin-changed mark
  assign port_changed = port_seen_q &&
    (|(port_prev_q ^ port_data_register));

  // Sticky per-kind change marks, since a change lands in the slot
  // written at the end of the running conversion
  logic norm_chg_q;
  logic prio_chg_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      norm_chg_q <= 1'b0;
      prio_chg_q <= 1'b0;
    end else begin
      if (normal_done) begin
        norm_chg_q <= 1'b0;
      end else if (normal_busy && port_changed) begin
        norm_chg_q <= 1'b1;
      end
      if (priority_done) begin
        prio_chg_q <= 1'b0;
      end else if (priority_busy && port_changed) begin
        prio_chg_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Slots
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INT; gi++) begin : g_slot
      if (gi < NUM_NORMAL) begin : g_norm
        // Channel index selects the normal slot
        assign wr_pulse[gi] = normal_done &&
          (normal_ch == CH_W'(gi));
        assign pin_pulse[gi] = wr_pulse[gi] &&
          (norm_chg_q || port_changed);
        assign slot_data[gi] = normal_data;
        assign rd_pulse[gi] = take && !hwrite &&
          (haddr == OFS_NORMAL_BASE + 8'(gi * 4));
      end else begin : g_prio
        assign wr_pulse[gi] = priority_done;
        assign pin_pulse[gi] = priority_done &&
          (prio_chg_q || port_changed);
        assign slot_data[gi] = priority_data;
        assign rd_pulse[gi] = take && !hwrite &&
          (haddr == OFS_PRIORITY);
      end
      adcrr_slot u_slot (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(wr_pulse[gi]),
        .wr_data(slot_data[gi]),
        .rd(rd_pulse[gi]),
        .pin_chg(pin_pulse[gi]),
        .result_q(slot_res[gi]),
        .stored_q(slot_st[gi]),
        .overrun_q(slot_ov[gi]),
        .pin_chg_q(slot_pc[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [NUM_INT-1:0] int_status_q;
  logic [NUM_INT-1:0] int_mask_q;
  logic wr_status;
  logic wr_mask;

  assign wr_status = ph_valid_q && ph_write_q &&
    (ph_addr_q == OFS_INT_STATUS);
  assign wr_mask = ph_valid_q && ph_write_q &&
    (ph_addr_q == OFS_INT_MASK);

  // A result arriving with the clearing write keeps its bit set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status_q <= INT_RST;
    end else if (wr_status) begin
      int_status_q <= (int_status_q & ~hwdata[NUM_INT-1:0]) | wr_pulse;
    end else begin
      int_status_q <= int_status_q | wr_pulse;
    end
  end

  // Mask register, one enables the matching status bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask_q <= INT_RST;
    end else if (wr_mask) begin
      int_mask_q <= hwdata[NUM_INT-1:0];
    end
  end

  assign irq = |(int_status_q & int_mask_q);

  // ****************************************************************
  // Read data: snapshot taken in the address phase, before clear
  // ****************************************************************
  logic [31:0] rd_word;
  integer k;

  always_comb begin
    rd_word = 32'h0000_0000;
    for (k = 0; k < NUM_INT; k++) begin
      if (rd_pulse[k]) begin
        rd_word = {17'h0_0000, slot_pc[k], slot_ov[k], slot_st[k],
          slot_res[k]};
      end
    end
    if (haddr == OFS_INT_STATUS) begin
      rd_word = {19'h0_0000, int_status_q};
    end else if (haddr == OFS_INT_MASK) begin
      rd_word = {19'h0_0000, int_mask_q};
    end
  end

  // Data output register; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_word;
    end
  end
endmodule : adcrr_top

// File: adcrr_pkg.sv
/*
  Package for the result register block: offsets, field positions,
  reset values and sizes shared by the result store and the bus slave.
  Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
// Contract
// - A normal conversion result lands in bits 11:0 of its slot.
// - Storing a normal result sets that slot's stored flag, bit 12.
// - Reading a normal slot clears its stored flag.
// - Overwriting an unread normal result sets its overrun flag, bit 13.
// - Reading a normal slot clears its overrun and pin-changed flags.
// - A shared port data change during normal conversion sets bit 14.
// - A priority result lands in bits 11:0 of the priority slot.
// - Storing a priority result sets its stored flag, bit 12.
// - Reading the priority slot clears its stored flag.
// - Overwriting an unread priority result sets its overrun flag.
// - Reading the priority slot clears its overrun flag.
// - A shared port data change during priority conversion sets bit 14.
// - Reading the priority slot clears its pin-changed flag.
package adcrr_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_NORMAL = 12;
  localparam int RES_W = 12;
  localparam int CH_W = 4;
  localparam int NUM_INT = NUM_NORMAL + 1;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_NORMAL_BASE = 8'h00;
  localparam logic [7:0] OFS_PRIORITY = 8'h30;
  localparam logic [7:0] OFS_INT_STATUS = 8'h34;
  localparam logic [7:0] OFS_INT_MASK = 8'h38;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_STORED = 12;
  localparam int BIT_OVERRUN = 13;
  localparam int BIT_PIN_CHG = 14;
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
  localparam logic [NUM_INT-1:0] INT_RST = 13'h0000;
endpackage : adcrr_pkg

// File: adcrr_slot.sv
/*
  One result register slot: result value plus stored, overrun and
  pin-changed flags. Assumes write, read and pin-change are one-cycle
  pulses from the top level in the hclk domain.
*/
`timescale 1ns/100ps
module adcrr_slot
  import adcrr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Events
  input wire logic wr,
  input wire logic [adcrr_pkg::RES_W-1:0] wr_data,
  input wire logic rd,
  input wire logic pin_chg,
  // State
  output logic [adcrr_pkg::RES_W-1:0] result_q,
  output logic stored_q,
  output logic overrun_q,
  output logic pin_chg_q
);
  import adcrr_pkg::*;

  // ****************************************************************
  // Result value
  // ****************************************************************
  // Result value, cleared only by reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= RESULT_RST;
    end else if (wr) begin
      result_q <= wr_data;
    end
  end

  // ****************************************************************
  // Flags: a set in the same cycle as a read wins, except overrun, which the read clears
  // ****************************************************************
  // Stored flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stored_q <= 1'b0;
    end else if (wr) begin
      stored_q <= 1'b1;
    end else if (rd) begin
      stored_q <= 1'b0;
    end
  end

  // Overrun: a write onto a still-unread value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_q <= 1'b0;
    end else if (wr && stored_q && !rd) begin
      overrun_q <= 1'b1;
    end else if (rd) begin
      overrun_q <= 1'b0;
    end
  end

  // Pin changed during conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_chg_q <= 1'b0;
    end else if (pin_chg) begin
      pin_chg_q <= 1'b1;
    end else if (rd) begin
      pin_chg_q <= 1'b0;
    end
  end
endmodule : adcrr_slot

// File: adcrr_top_assertions.sv
/* Checker for adcrr_top: assertions and covers on its ports.
   Assumes the bus hready is the slave's own hreadyout. */
`timescale 1ns/100ps
module adcrr_chk #(
  parameter int PORT_W = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Converter, port and interrupt
  input wire logic normal_busy,
  input wire logic normal_done,
  input wire logic [3:0] normal_ch,
  input wire logic [11:0] normal_data,
  input wire logic priority_busy,
  input wire logic priority_done,
  input wire logic [11:0] priority_data,
  input wire logic [PORT_W-1:0] port_data_register,
  input wire logic irq
);
  // Read address phases of slot 0 and of the priority slot
  wire logic rq = hsel && hready && htrans[1] && !hwrite;
  wire logic r0 = rq && haddr == 8'h00;
  wire logic rp = rq && haddr == 8'h30;
  wire logic d0 = normal_done && normal_ch == 4'h0;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ********
  // Properties
  // ********
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_HIGH_ZERO: assert property (hrdata[31:15] == 17'h0_0000)
    else $error("upper read bits not zero");
  AST_RST: assert property ($rose(hresetn) |-> hrdata == 0 && !irq)
    else $error("outputs not clear after reset");
  AST_N_STORE: assert property (d0 ##1 r0 |=> hrdata[12] &&
    hrdata[11:0] == $past(normal_data, 2)) else $error("normal store");
  AST_N_CLEAR: assert property ((r0 && !normal_busy && !normal_done) ##1
    !normal_done ##1 (r0 && !normal_done) |=> hrdata[14:12] == 3'h0)
    else $error("normal flags not cleared");
  AST_N_OVR: assert property (d0 ##1 (d0 && !r0) ##1 r0 |=> hrdata[13])
    else $error("normal overrun missing");
  AST_N_PIN: assert property ((normal_busy && port_data_register !=
    $past(port_data_register)) ##1 d0 ##1 r0 |=> hrdata[14])
    else $error("normal pin flag missing");
  AST_P_STORE: assert property (priority_done ##1 rp |=> hrdata[12] &&
    hrdata[11:0] == $past(priority_data, 2)) else $error("priority store");
  AST_P_CLEAR: assert property ((rp && !priority_busy && !priority_done) ##1
    !priority_done ##1 (rp && !priority_done) |=> hrdata[14:12] == 3'h0)
    else $error("priority flags not cleared");
  AST_P_OVR: assert property (priority_done ##1 (priority_done && !rp)
    ##1 rp |=> hrdata[13]) else $error("priority overrun missing");
  AST_P_PIN: assert property ((priority_busy && port_data_register !=
    $past(port_data_register)) ##1 priority_done ##1 rp |=> hrdata[14])
    else $error("priority pin flag missing");
  // Main scenarios
  cover property (d0 ##1 (d0 && !r0));
  cover property (priority_done ##1 rp);
  cover property (irq);
endmodule : adcrr_chk
bind adcrr_top adcrr_chk #(.PORT_W(PORT_W)) adcrr_chk_inst (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .normal_busy(normal_busy),
  .normal_done(normal_done),
  .normal_ch(normal_ch),
  .normal_data(normal_data),
  .priority_busy(priority_busy),
  .priority_done(priority_done),
  .priority_data(priority_data),
  .port_data_register(port_data_register),
  .irq(irq)
);

// File: adcrr_top_tb.sv
/* Self-checking bench for adcrr_top: bus reads, conversions, irq.
   Assumes zero-wait-state answers; every wait is still bounded. */
`timescale 1ns/100ps
module adcrr_top_tb;
  import adcrr_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0, hrdata, got, r;
  logic hreadyout, hresp, irq, normal_busy = 0, normal_done = 0;
  logic priority_busy = 0, priority_done = 0;
  logic [3:0] normal_ch = 0;
  logic [11:0] normal_data = 0, priority_data = 0, port_data_register = 0;
  logic [11:0] res [13];
  logic [12:0] st = 0, ov = 0, pc = 0, stat = 0, m;
  int err_count = 0, num_checks = 0, seed = 32'h443a_3957;
  wire logic hready = hreadyout;
  adcrr_top adcrr_top_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .normal_busy(normal_busy),
    .normal_done(normal_done),
    .normal_ch(normal_ch),
    .normal_data(normal_data),
    .priority_busy(priority_busy),
    .priority_done(priority_done),
    .priority_data(priority_data),
    .port_data_register(port_data_register),
    .irq(irq)
  );
  always #12.5 hclk = !hclk;
  // ********
  // Checks and bus cycles
  // ********
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task chk_w(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: word %h not %h", $time, g, e);
    end
  endtask : chk_w
  task chk_b(input logic g, e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: irq %b", $time, g);
    end
  endtask : chk_b
  // Bounded wait for hready, so a stuck slave ends the run
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: bus hang", $time);
      summarize;
    end
  endtask : wt
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    wt;
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    wt;
    got = hrdata;
  endtask : ahb
  function logic [31:0] expw(int k);
    return {17'h0_0000, pc[k], ov[k], st[k], res[k]};
  endfunction : expw
  // Read a slot and compare; a read clears all three flags
  task rchk(int k);
    logic [31:0] e;
    e = expw(k);
    ahb(0, 8'(4 * k), 0);
    chk_w(got, e);
    st[k] = 0;
    ov[k] = 0;
    pc[k] = 0;
  endtask : rchk
  // Conversion of kind p with n back-to-back results
  task conv(input logic p, input logic [3:0] ch, input int n, input logic t);
    int k;
    k = p ? 12 : ch;
    // Let an edge pass so busy is never driven twice in one step
    @(posedge hclk);
    normal_busy <= !p;
    priority_busy <= p;
    @(posedge hclk);
    if (t) port_data_register <= port_data_register ^ (12'h001 << ch);
    @(posedge hclk);
    for (int j = 0; j < n; j++) begin
      r = $random(seed);
      normal_done <= !p;
      priority_done <= p;
      normal_ch <= ch;
      normal_data <= r[11:0];
      priority_data <= r[11:0];
      ov[k] = ov[k] | st[k];
      st[k] = 1;
      stat[k] = 1;
      res[k] = r[11:0];
      pc[k] = pc[k] | (t && j == 0);
      @(posedge hclk);
    end
    normal_done <= 0;
    priority_done <= 0;
    normal_busy <= 0;
    priority_busy <= 0;
  endtask : conv
  // ********
  // Main sequence
  // ********
  initial begin
    foreach (res[k]) res[k] = 12'h000;
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    for (int k = 0; k < 13; k++) rchk(k);
    chk_b(irq, 0);
    $display("test reset done");
    conv(0, 0, 2, 1);
    rchk(0);
    rchk(0);
    conv(1, 0, 2, 1);
    rchk(12);
    rchk(12);
    ahb(1, 8'h30, $random(seed));
    rchk(12);
    ahb(0, 8'h3c, 0);
    chk_w(got, 0);
    $display("test corners done");
    repeat (30) begin
      r = $random(seed);
      conv(r[0], 4'(r[7:4] % 4'd12), 1 + r[8], r[9]);
      if (r[10]) rchk(r[0] ? 12 : int'(r[7:4] % 4'd12));
    end
    $display("test random done");
    m = 13'($random(seed));
    ahb(1, 8'h38, {19'h0_0000, m});
    @(negedge hclk);
    chk_b(irq, |(stat & m));
    ahb(0, 8'h34, 0);
    chk_w(got, {19'h0_0000, stat});
    ahb(1, 8'h34, 32'h0000_1fff);
    @(negedge hclk);
    chk_b(irq, 0);
    ahb(1, 8'h38, 32'h0000_1fff);
    conv(0, 3, 1, 0);
    @(negedge hclk);
    chk_b(irq, 1);
    for (int k = 0; k < 13; k++) rchk(k);
    $display("test irq done");
    // Mid-run reset: stored results and the pending irq must clear
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk_b(irq, 0);
    foreach (res[k]) res[k] = 12'h000;
    for (int k = 0; k < 13; k++) rchk(k);
    $display("test mid-run reset done");
    summarize;
  end
endmodule : adcrr_top_tb
